// >>> uicid_pkg.sv
// Package for the interrupt clear and identification register slice.
// Assumes a plain word-addressed register port with byte offsets.
package uicid_pkg;
  // ==========================================================
  // Register offsets
  localparam logic [11:0] UICID_OFF_ICR   = 12'h044;
  localparam logic [11:0] UICID_OFF_RIS   = 12'h03c;
  localparam logic [11:0] UICID_OFF_IMR   = 12'h038;
  localparam logic [11:0] UICID_OFF_IDH0  = 12'hfd0;
  localparam logic [11:0] UICID_OFF_IDH1  = 12'hfd4;
  localparam logic [11:0] UICID_OFF_IDH2  = 12'hfd8;
  localparam logic [11:0] UICID_OFF_IDH3  = 12'hfdc;
  localparam logic [11:0] UICID_OFF_IDL0  = 12'hfe0;
  localparam logic [11:0] UICID_OFF_IDL1  = 12'hfe4;
  localparam logic [11:0] UICID_OFF_IDL2  = 12'hfe8;
  // ==========================================================
  // Field positions of the four sources
  localparam int UICID_BIT_RX  = 4;
  localparam int UICID_BIT_TX  = 5;
  localparam int UICID_BIT_RT  = 6;
  localparam int UICID_BIT_FE  = 7;
  localparam int UICID_NSRC    = 4;
  localparam int UICID_LSB     = UICID_BIT_RX;
  // ==========================================================
  // Reset values
  localparam logic [3:0]  UICID_RST_SRC  = 4'h0;
  localparam logic [31:0] UICID_RST_WORD = 32'h0000_0000;
  // Identity bytes, values arbitrary
  localparam logic [7:0]  UICID_DEF_IDH0 = 8'h21;
  localparam logic [7:0]  UICID_DEF_IDH1 = 8'h43;
  localparam logic [7:0]  UICID_DEF_IDH2 = 8'h65;
  localparam logic [7:0]  UICID_DEF_IDH3 = 8'h87;
  localparam logic [7:0]  UICID_DEF_IDL0 = 8'h5a;
  localparam logic [7:0]  UICID_DEF_IDL1 = 8'ha9;
  localparam logic [7:0]  UICID_DEF_IDL2 = 8'h3c;
endpackage : uicid_pkg

// >>> uicid_regs.sv
// Interrupt clear and identification registers of a serial port.
// Assumes one clock, a synchronous active-low reset, and event pulses
// from the transmitter and receiver on the same clock.
//
// Notes on behaviour
// - Writing one to bit 7 clears the framing-error interrupt.
// - Writing one to bit 6 clears the receive time-out interrupt.
// - Writing one to bit 5 clears the transmit interrupt.
// - Writing one to bit 4 clears the receive interrupt.
// - Writing zero leaves interrupts unchanged; clear bits read zero.
// - Bits 3 to 0 of the clear register are reserved, read zero.
// - Identification registers are read-only constants in bits 7 to 0.
// - Bits 31 to 8 of identification registers read zero.
// - Offsets 0xfd0 to 0xfdc give upper word bytes zero to three.
// - Offsets 0xfe0, 0xfe4, 0xfe8 give lower word bytes zero to two.
// - A clear removes raw and masked status together.
// - Clear register at offset 0x044, resets to zero.
//
// Chosen here: the address-and-strobe port.
module uicid_regs
  import uicid_pkg::*;
#(
  parameter logic [7:0] ID_HI0 = UICID_DEF_IDH0,
  parameter logic [7:0] ID_HI1 = UICID_DEF_IDH1,
  parameter logic [7:0] ID_HI2 = UICID_DEF_IDH2,
  parameter logic [7:0] ID_HI3 = UICID_DEF_IDH3,
  parameter logic [7:0] ID_LO0 = UICID_DEF_IDL0,
  parameter logic [7:0] ID_LO1 = UICID_DEF_IDL1,
  parameter logic [7:0] ID_LO2 = UICID_DEF_IDL2
) (
  input  wire logic        clk,
  input  wire logic        rst_b,
  input  wire logic [11:0] addr,
  input  wire logic [31:0] wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  output logic      [31:0] rdata,
  input  wire logic [3:0]  src_event,
  output logic      [3:0]  raw_status,
  output logic      [3:0]  masked_status,
  output logic             irq
);

  // ==========================================================
  // Elaboration checks
  // Clear field, mask and status read-back share one contiguous layout
  if (UICID_NSRC != 4) begin : g_bad_nsrc
    $error("uicid_regs serves exactly four interrupt sources");
  end
  if (UICID_LSB + UICID_NSRC > 8) begin : g_bad_field
    $error("uicid_regs needs the clear field inside bits 7 to 0");
  end
  if (UICID_BIT_RX != UICID_LSB) begin : g_bad_rx
    $error("uicid_regs needs the receive bit at the bottom of the field");
  end
  if (UICID_BIT_TX != UICID_LSB + 1) begin : g_bad_tx
    $error("uicid_regs needs the transmit bit next to the receive bit");
  end
  if (UICID_BIT_RT != UICID_LSB + 2) begin : g_bad_rt
    $error("uicid_regs needs the time-out bit next to the transmit bit");
  end
  if (UICID_BIT_FE != UICID_LSB + 3) begin : g_bad_fe
    $error("uicid_regs needs the framing bit at the top of the field");
  end
  if (UICID_OFF_ICR[1:0] != 2'b00 || UICID_OFF_IMR[1:0] != 2'b00) begin : g_bad_align
    $error("uicid_regs needs word-aligned register offsets");
  end
  if (UICID_OFF_IMR == UICID_OFF_ICR || UICID_OFF_RIS == UICID_OFF_ICR) begin : g_bad_overlap
    $error("uicid_regs needs distinct control register offsets");
  end
  if (UICID_OFF_IDH0[11:8] != 4'hf || UICID_OFF_IDL2[11:8] != 4'hf) begin : g_bad_idmap
    $error("uicid_regs needs the identity registers in the top page");
  end

  // ==========================================================
  // Source state
  logic [3:0] raw_r;
  logic [3:0] raw_nxt;
  logic [3:0] mask_r;
  logic [3:0] clr_hit;

  assign clr_hit = (wr && addr == UICID_OFF_ICR) ?
                   wdata[UICID_LSB +: UICID_NSRC] : 4'h0;

  // Set wins over a clear in the same cycle
  assign raw_nxt = (raw_r & ~clr_hit) | src_event;

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      raw_r <= UICID_RST_SRC;
    end else begin
      raw_r <= raw_nxt;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      mask_r <= UICID_RST_SRC;
    end else if (wr && addr == UICID_OFF_IMR) begin
      mask_r <= wdata[UICID_LSB +: UICID_NSRC];
    end
  end

  // ==========================================================
  // Status outputs, registered from next state
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      raw_status <= UICID_RST_SRC;
    end else begin
      raw_status <= raw_nxt;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      masked_status <= UICID_RST_SRC;
    end else begin
      masked_status <= raw_nxt & mask_r;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      irq <= 1'b0;
    end else begin
      irq <= |(raw_nxt & mask_r);
    end
  end

  // ==========================================================
  // Read decode
  logic [31:0] rd_val;

  always_comb begin
    rd_val = UICID_RST_WORD;
    case (addr)
      UICID_OFF_ICR:  rd_val = UICID_RST_WORD;
      UICID_OFF_RIS:  rd_val[UICID_LSB +: UICID_NSRC] = raw_r;
      UICID_OFF_IMR:  rd_val[UICID_LSB +: UICID_NSRC] = mask_r;
      UICID_OFF_IDH0: rd_val[7:0] = ID_HI0;
      UICID_OFF_IDH1: rd_val[7:0] = ID_HI1;
      UICID_OFF_IDH2: rd_val[7:0] = ID_HI2;
      UICID_OFF_IDH3: rd_val[7:0] = ID_HI3;
      UICID_OFF_IDL0: rd_val[7:0] = ID_LO0;
      UICID_OFF_IDL1: rd_val[7:0] = ID_LO1;
      UICID_OFF_IDL2: rd_val[7:0] = ID_LO2;
      default:        rd_val = UICID_RST_WORD;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      rdata <= UICID_RST_WORD;
    end else if (rd) begin
      rdata <= rd_val;
    end else begin
      rdata <= UICID_RST_WORD;
    end
  end

  // ==========================================================
  // Checks
  a_clear_drops_raw: assert property (@(posedge clk) disable iff (!rst_b)
    (wr && addr == UICID_OFF_ICR && wdata[UICID_BIT_FE] && !src_event[3])
    |=> !raw_status[3])
    else $error("framing clear did not drop status");
  a_rt_clear: assert property (@(posedge clk) disable iff (!rst_b)
    (wr && addr == UICID_OFF_ICR && wdata[UICID_BIT_RT] && !src_event[2])
    |=> !raw_status[2])
    else $error("time-out clear did not drop status");
  a_tx_clear: assert property (@(posedge clk) disable iff (!rst_b)
    (wr && addr == UICID_OFF_ICR && wdata[UICID_BIT_TX] && !src_event[1])
    |=> !raw_status[1])
    else $error("transmit clear did not drop status");
  a_rx_clear: assert property (@(posedge clk) disable iff (!rst_b)
    (wr && addr == UICID_OFF_ICR && wdata[UICID_BIT_RX] && !src_event[0])
    |=> !raw_status[0])
    else $error("receive clear did not drop status");
  a_zero_keeps: assert property (@(posedge clk) disable iff (!rst_b)
    (wr && addr == UICID_OFF_ICR && !wdata[UICID_BIT_FE] && raw_r[3])
    |=> raw_status[3])
    else $error("zero write changed status");
  a_icr_reads_zero: assert property (@(posedge clk) disable iff (!rst_b)
    (rd && addr == UICID_OFF_ICR) |=> rdata == 32'h0000_0000)
    else $error("clear register read nonzero");
  a_id_upper_read: assert property (@(posedge clk) disable iff (!rst_b)
    (rd && addr == UICID_OFF_IDH3) |=> rdata == {24'h000000, ID_HI3})
    else $error("upper identity byte wrong");
  a_id_lower_read: assert property (@(posedge clk) disable iff (!rst_b)
    (rd && addr == UICID_OFF_IDL2) |=> rdata == {24'h000000, ID_LO2})
    else $error("lower identity byte wrong");
  a_id_reserved: assert property (@(posedge clk) disable iff (!rst_b)
    (rd && addr[11:4] >= 8'hfd && addr[11:4] <= 8'hfe) |=> rdata[31:8] == 24'h000000)
    else $error("identity reserved bits nonzero");
  a_masked_tracks: assert property (@(posedge clk) disable iff (!rst_b)
    masked_status == (raw_status & $past(mask_r)))
    else $error("masked status not tied to raw");
  a_irq_drop: assert property (@(posedge clk) disable iff (!rst_b)
    (wr && addr == UICID_OFF_ICR && (&wdata[7:4]) && src_event == 4'h0)
    |=> !irq)
    else $error("interrupt did not drop after clear");
  a_id_no_write: assert property (@(posedge clk) disable iff (!rst_b)
    (wr && addr == UICID_OFF_IDL0) ##[1:2] (rd && addr == UICID_OFF_IDL0)
    |=> rdata == {24'h000000, ID_LO0})
    else $error("identity changed by write");

  // ==========================================================
  // Check helpers
  // Registered read strobe: rdata may only be nonzero after a read
  logic chk_rd_r;

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      chk_rd_r <= 1'b0;
    end else begin
      chk_rd_r <= rd;
    end
  end

  // ==========================================================
  // Register bus checks
  a_rdata_idle: assert property (@(posedge clk) disable iff (!rst_b)
    !chk_rd_r |-> rdata == 32'h0000_0000)
    else $error("read data not zero outside a read");

  a_mask_read: assert property (@(posedge clk) disable iff (!rst_b)
    (rd && addr == UICID_OFF_IMR) |=> rdata == {24'h000000, $past(mask_r), 4'h0})
    else $error("mask read-back wrong");

  a_raw_read: assert property (@(posedge clk) disable iff (!rst_b)
    (rd && addr == UICID_OFF_RIS) |=> rdata == {24'h000000, $past(raw_r), 4'h0})
    else $error("raw status read-back wrong");

  a_mask_write: assert property (@(posedge clk) disable iff (!rst_b)
    (wr && addr == UICID_OFF_IMR) |=> mask_r == $past(wdata[UICID_LSB +: UICID_NSRC]))
    else $error("mask write not taken");

  a_mask_hold: assert property (@(posedge clk) disable iff (!rst_b)
    !(wr && addr == UICID_OFF_IMR) |=> $stable(mask_r))
    else $error("mask changed without a write");

  a_unmapped_zero: assert property (@(posedge clk) disable iff (!rst_b)
    (rd && addr[11:8] != 4'hf && addr != UICID_OFF_ICR && addr != UICID_OFF_RIS &&
     addr != UICID_OFF_IMR) |=> rdata == 32'h0000_0000)
    else $error("unmapped read nonzero");

  a_status_wr_ignored: assert property (@(posedge clk) disable iff (!rst_b)
    (wr && addr == UICID_OFF_RIS && src_event == 4'h0) |=> raw_status == $past(raw_r))
    else $error("status write changed status");

  a_id_wr_ignored: assert property (@(posedge clk) disable iff (!rst_b)
    (wr && addr[11:8] == 4'hf && src_event == 4'h0) |=> raw_status == $past(raw_r))
    else $error("identity write changed status");

  // ==========================================================
  // Reset and interrupt checks
  a_reset_clean: assert property (@(posedge clk)
    !rst_b |=> rdata == 32'h0000_0000 && raw_status == 4'h0 &&
      masked_status == 4'h0 && !irq)
    else $error("outputs not cleared by reset");

  a_reset_mask: assert property (@(posedge clk)
    !rst_b |=> mask_r == 4'h0)
    else $error("mask not cleared by reset");

  a_irq_level: assert property (@(posedge clk) disable iff (!rst_b)
    irq == |masked_status)
    else $error("interrupt not the OR of masked status");

  a_raw_tracks: assert property (@(posedge clk) disable iff (!rst_b)
    raw_status == raw_r)
    else $error("raw status output not the sticky flags");

  // ==========================================================
  // Per-source checks
  // Bit s of the status ports pairs with bit LSB+s of the clear word
  for (genvar s = 0; s < UICID_NSRC; s++) begin : g_src_chk
    a_set_wins: assert property (@(posedge clk) disable iff (!rst_b)
      src_event[s] |=> raw_status[s])
      else $error("event did not set status");

    a_clear_bit: assert property (@(posedge clk) disable iff (!rst_b)
      (wr && addr == UICID_OFF_ICR && wdata[UICID_LSB + s] && !src_event[s])
      |=> !raw_status[s] && !masked_status[s])
      else $error("clear left a status view set");

    a_zero_holds: assert property (@(posedge clk) disable iff (!rst_b)
      raw_r[s] && !(wr && addr == UICID_OFF_ICR && wdata[UICID_LSB + s])
      |=> raw_status[s])
      else $error("status lost without a clear");

    a_no_spurious: assert property (@(posedge clk) disable iff (!rst_b)
      !src_event[s] && !raw_r[s] |=> !raw_status[s])
      else $error("status set without an event");

    a_mask_gates: assert property (@(posedge clk) disable iff (!rst_b)
      !mask_r[s] |=> !masked_status[s])
      else $error("masked status set while masked");

    a_irq_rise: assert property (@(posedge clk) disable iff (!rst_b)
      src_event[s] && mask_r[s] |=> irq)
      else $error("unmasked event raised no interrupt");

    a_masked_bit: assert property (@(posedge clk) disable iff (!rst_b)
      masked_status[s] == (raw_status[s] && $past(mask_r[s])))
      else $error("masked bit not raw and mask");
  end

  // ==========================================================
  // Identity checks
  // Table order follows the read decode above
  localparam int          ID_COUNT = 7;
  localparam logic [11:0] ID_OFF [ID_COUNT] = '{
    UICID_OFF_IDH0,
    UICID_OFF_IDH1,
    UICID_OFF_IDH2,
    UICID_OFF_IDH3,
    UICID_OFF_IDL0,
    UICID_OFF_IDL1,
    UICID_OFF_IDL2
  };
  localparam logic [7:0]  ID_VAL [ID_COUNT] = '{
    ID_HI0,
    ID_HI1,
    ID_HI2,
    ID_HI3,
    ID_LO0,
    ID_LO1,
    ID_LO2
  };

  for (genvar k = 0; k < ID_COUNT; k++) begin : g_id_chk
    a_id_value: assert property (@(posedge clk) disable iff (!rst_b)
      (rd && addr == ID_OFF[k]) |=> rdata == {24'h000000, ID_VAL[k]})
      else $error("identity byte wrong");

    a_id_top_zero: assert property (@(posedge clk) disable iff (!rst_b)
      (rd && addr == ID_OFF[k]) |=> rdata[31:8] == 24'h000000)
      else $error("identity upper bits nonzero");

    a_id_kept: assert property (@(posedge clk) disable iff (!rst_b)
      (wr && addr == ID_OFF[k]) ##[1:2] (rd && addr == ID_OFF[k])
      |=> rdata == {24'h000000, ID_VAL[k]})
      else $error("identity byte changed by write");
  end

endmodule // uicid_regs

// >>> uicid_tb.sv
// Self-checking bench for the interrupt clear and identification slice.
// Assumes uicid_regs alone, its ports driven directly by this module.
module testbench
  import uicid_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  // ==========================================================
  // Signals and instance
  logic        clk = 1'b0;
  logic        rst_b;
  logic [11:0] addr;
  logic [31:0] wdata;
  logic        wr;
  logic        rd;
  logic [31:0] rdata;
  logic [3:0]  src_event;
  logic [3:0]  raw_status;
  logic [3:0]  masked_status;
  logic        irq;
  int          fail_count;
  int          total_checks;
  // Identity bytes, values arbitrary
  localparam logic [7:0]  IDV [7] = '{8'ha1, 8'hb2, 8'hc3, 8'hd4, 8'he5, 8'hf6, 8'h97};
  localparam logic [11:0] IDA [7] = '{UICID_OFF_IDH0, UICID_OFF_IDH1, UICID_OFF_IDH2,
    UICID_OFF_IDH3, UICID_OFF_IDL0, UICID_OFF_IDL1, UICID_OFF_IDL2};
  always #2 clk = ~clk;
  uicid_regs #(.ID_HI0(IDV[0]), .ID_HI1(IDV[1]), .ID_HI2(IDV[2]), .ID_HI3(IDV[3]),
    .ID_LO0(IDV[4]), .ID_LO1(IDV[5]), .ID_LO2(IDV[6])) dut (.clk(clk), .rst_b(rst_b),
    .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .src_event(src_event),
    .raw_status(raw_status), .masked_status(masked_status), .irq(irq));
  // ==========================================================
  // Access tasks
  task automatic chk(string n, logic [31:0] e, logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr_reg(logic [11:0] a, logic [31:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr    <= 1'b0;
    #1;
  endtask
  task automatic rd_chk(logic [11:0] a, logic [31:0] e, string n);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd   <= 1'b0;
    #1;
    chk(n, e, rdata);
  endtask
  task automatic pulse(logic [3:0] s);
    @(posedge clk);
    src_event <= s;
    @(posedge clk);
    src_event <= 4'h0;
    #1;
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // ==========================================================
  // Tests
  initial begin
    rst_b = 1'b0;
    addr = 12'h000;
    wdata = 32'h0;
    wr = 1'b0;
    rd = 1'b0;
    src_event = 4'h0;
    fail_count = 0;
    total_checks = 0;
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    #1;
    chk("irq", 32'h0, {31'h0, irq});
    rd_chk(UICID_OFF_ICR, 32'h0, "clear_reg");
    $display("test reset done");
    for (int i = 0; i < 7; i++) begin
      rd_chk(IDA[i], {24'h0, IDV[i]}, "ident");
      wr_reg(IDA[i], 32'hffff_ffff);
      rd_chk(IDA[i], {24'h0, IDV[i]}, "ident_wr");
    end
    rd_chk(12'h100, 32'h0, "unmapped");
    $display("test ident done");
    wr_reg(UICID_OFF_IMR, 32'h0000_00f0);
    for (int i = 0; i < 4; i++) begin
      pulse(4'h1 << i);
      chk("raw", {28'h0, 4'h1 << i}, {28'h0, raw_status});
      wr_reg(UICID_OFF_ICR, 32'h0000_00f0 & ~(32'h10 << i));
      chk("raw_kept", {28'h0, 4'h1 << i}, {28'h0, raw_status});
      chk("irq_kept", 32'h1, {31'h0, irq});
      rd_chk(UICID_OFF_ICR, 32'h0, "clear_rd");
      wr_reg(UICID_OFF_ICR, 32'h10 << i);
      chk("raw_clr", 32'h0, {28'h0, raw_status});
      chk("mis_clr", 32'h0, {28'h0, masked_status});
      chk("irq_clr", 32'h0, {31'h0, irq});
    end
    $display("test clear done");
    wr_reg(UICID_OFF_IMR, 32'h0);
    pulse(4'hf);
    chk("mis_off", 32'h0, {28'h0, masked_status});
    wr_reg(UICID_OFF_RIS, 32'h0);
    rd_chk(UICID_OFF_RIS, 32'h0000_00f0, "raw_rd");
    wr_reg(UICID_OFF_ICR, 32'h0000_00f0);
    chk("raw_all", 32'h0, {28'h0, raw_status});
    $display("test mask done");
    @(posedge clk);
    src_event <= 4'h1;
    addr      <= UICID_OFF_ICR;
    wdata     <= 32'h0000_0010;
    wr        <= 1'b1;
    @(posedge clk);
    src_event <= 4'h0;
    wr        <= 1'b0;
    #1;
    chk("set_wins", 32'h1, {28'h0, raw_status});
    wr_reg(UICID_OFF_ICR, 32'h0000_0010);
    chk("raw_end", 32'h0, {28'h0, raw_status});
    $display("test set wins done");
    print_verdict();
  end
endmodule // testbench
